// ---- opw_pkg.sv ----
// Shared constants for the one-time program memory writer and its programmer.
package opw_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000; // Core clock rate.
  localparam int PROG_TIME_NS = 1000; // Duration of one byte program.
  localparam int HWD_WAIT_NS = 1000; // Least gap before hardware disable.
  localparam int RST_WAIT_MS = 20; // Least wait after a pin reset.
  // Least times round up to whole cycles.
  localparam int PROG_CYC = (PROG_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int HWD_CYC = (HWD_WAIT_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int RST_WAIT_CYC = RST_WAIT_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Link register selects
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_DEVICE_CONTROL_REG = 8'h02; // Device control register.
  localparam logic [7:0] SEL_PCTL = 8'h03; // Programming control register.
  localparam logic [7:0] SEL_PADDRH = 8'h04; // Programming address high.
  localparam logic [7:0] SEL_PADDRL = 8'h05; // Programming address low.
  localparam logic [7:0] SEL_PDATA = 8'h06; // Programming data register.

  // Command values written over the link.
  localparam logic [7:0] DEVICE_CONTROL_REG_HOLD = 8'h04;
  localparam logic [7:0] DEVICE_CONTROL_REG_RST = 8'h02;
  localparam logic [7:0] DEVICE_CONTROL_REG_GO = 8'h00;
  localparam logic [7:0] PCTL_ARM = 8'h40;
  localparam logic [7:0] PCTL_ON_NEW = 8'h4a;
  localparam logic [7:0] PCTL_ON_OLD = 8'h58;
  localparam logic [7:0] PCTL_OFF = 8'h00;
  // Status bits returned by an address read.
  localparam int ST_BUSY = 7;
  localparam int ST_ERR = 6;

  // ----------------------------------------------------------------
  // Firmware register addresses and values
  // ----------------------------------------------------------------
  localparam logic [7:0] SFR_STORE = 8'h8f; // Store control register.
  localparam logic [7:0] SFR_KEY = 8'hb7; // Unlock key register.
  localparam logic [7:0] SFR_IAP = 8'ha8; // In-application control.
  localparam logic [7:0] SFR_VMON = 8'hff; // Supply monitor control.
  localparam logic [7:0] SFR_RSRC = 8'hef; // Reset source register.
  localparam logic [7:0] KEY_1 = 8'ha5;
  localparam logic [7:0] KEY_2 = 8'hf1;
  localparam int IAP_EN_BIT = 7;
  localparam int IAP_HWD_BIT = 6;
  localparam int VMON_EN_BIT = 7;
  localparam int RSRC_VMON_BIT = 1;

  // ----------------------------------------------------------------
  // Memory map
  // ----------------------------------------------------------------
  localparam logic [15:0] SEC_ADDR_LARGE = 16'hfff8;
  localparam logic [15:0] SEC_ADDR_SMALL = 16'h3ff8;
  localparam logic [7:0] BLANK_BYTE = 8'hff; // Unprogrammed byte value.

  // ----------------------------------------------------------------
  // Programmer host registers on the bus
  // ----------------------------------------------------------------
  localparam logic [31:0] HREG_CMD = 32'h0000_0000;
  localparam logic [31:0] HREG_STAT = 32'h0000_0004;
  localparam logic [31:0] HREG_PIN = 32'h0000_0008;

  // Program mode state, Gray coded along the entry and exit path.
  typedef enum logic [1:0] {
    PM_OFF = 2'b00,
    PM_ARM = 2'b01,
    PM_ON = 2'b11,
    PM_EXIT = 2'b10
  } opw_pm_e;

endpackage : opw_pkg

// ---- opw_link_if.sv ----
// Debug programming link between the programmer and the device.
`timescale 1ns/1ps
`default_nettype none
interface opw_link_if;
  logic req; // One-cycle request strobe.
  logic addr_rd; // Request is a status (address) read.
  logic we; // Request is a register write.
  logic [7:0] sel; // Register select.
  logic [7:0] wdata; // Write data.
  logic ack; // One-cycle answer strobe.
  logic [7:0] rdata; // Read data, valid with ack.
  logic vpp_on; // Programming voltage applied.

  modport dev (
    input req, addr_rd, we, sel, wdata, vpp_on,
    output ack, rdata
  );
  modport prg (
    output req, addr_rd, we, sel, wdata, vpp_on,
    input ack, rdata
  );
endinterface : opw_link_if
`default_nettype wire

// ---- opw_device.sv ----
// Device end: one-time program memory with link and firmware write paths.
// Functional notes
// [R1] Each byte programs once; no erase.
// [R2] Programmer waits 20 ms after pin reset.
// [R3] Control write 0x04 holds core in reset.
// [R4] Program mode needs 0x40 then 0x4A.
// [R5] Old revisions use 0x58 as second value.
// [R6] Programmer loads address before writing data.
// [R7] Data write programs byte, address increments.
// [R8] Programmer polls busy; error flags failed write.
// [R9] Next byte: auto address or reload address.
// [R10] Exit program mode with 0x40 then 0x00.
// [R11] Control 0x02 then 0x00 resets device.
// [R12] One store programs exactly one byte.
// [R13] Store enable plus key pair unlocks writes.
// [R14] Firmware writes need in-application enable set.
// [R15] Firmware slows clock, disables prefetch, interrupts.
// [R16] Write without supply monitor reset triggers reset.
// [R17] Hardware disable honoured 1 us after write.
// [R18] Firmware sets pin open-drain, latch one.
// [R19] Security byte at fixed address, always readable.
// [R20] Write-lock bits block link writes.
// [R21] Read-lock bits block link reads.
// [R22] Interrupts stay pending during writes.
// [R23] Busy spans each byte program operation.
`timescale 1ns/1ps
`default_nettype none
module opw_device #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Programming link
  opw_link_if.dev link,
  // Firmware register writes
  input wire logic sfr_we,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  // Firmware external-data stores
  input wire logic xs_valid,
  input wire logic [15:0] xs_addr,
  input wire logic [7:0] xs_data,
  // Interrupt requests and delivery
  input wire logic [3:0] irq_req,
  input wire logic irq_enable,
  output logic irq_valid,
  output logic [1:0] irq_id,
  // Reset and pin control
  output logic core_hold,
  output logic dev_reset,
  output logic vpp_gpio_en
);
  import opw_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem_q [0:65535]; // Programmed byte values.
  bit done_q [0:65535]; // Set once a byte has been programmed.

  // Byte read as seen by anyone: blank until programmed.
  function automatic logic [7:0] rd_byte(input logic [15:0] a);
    rd_byte = done_q[a] ? mem_q[a] : BLANK_BYTE;
  endfunction : rd_byte

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic vpp_s1_q, vpp_s2_q; // Pin synchroniser.
  opw_pm_e pm_q; // Program mode state.
  logic rst_arm_q; // Reset command armed.
  logic [15:0] paddr_q; // Link programming address.
  logic [7:0] cnt_q; // Program operation countdown.
  logic err_q; // Last write failed.
  logic [7:0] gap_q; // Cycles since the last program ended.
  logic store_we_q, iap_en_q, hwd_pend_q, vmon_q, rsrc_q;
  logic [1:0] key_q; // Unlock progress: 2 means unlocked.
  logic [3:0] pend_q; // Held interrupt requests.
  logic [7:0] sec_byte;
  logic busy, lk_start, iap_try, iap_start, iap_bad, wlock, rlock;
  logic [15:0] sec_addr;
  logic [15:0] wr_addr;
  logic [7:0] wr_data;

  assign busy = (cnt_q != 8'h00); // R23
  assign sec_addr = LARGE_VARIANT ? SEC_ADDR_LARGE : SEC_ADDR_SMALL; // R19
  assign sec_byte = rd_byte(sec_addr); // R19
  assign wlock = (sec_byte[7:4] != 4'hf); // R20
  assign rlock = (sec_byte[3:0] != 4'hf); // R21
  // Link data writes need program mode, voltage, no lock, idle.
  assign lk_start = link.req && link.we && !link.addr_rd &&
    (link.sel == SEL_PDATA) && (pm_q == PM_ON) && vpp_s2_q &&
    !wlock && !busy; // R20
  // Stores reach program memory only with the store enable.
  assign iap_try = xs_valid && store_we_q;
  assign iap_bad = !(vmon_q && rsrc_q); // R16
  assign iap_start = iap_try && (key_q == 2'd2) && iap_en_q && !busy &&
    !iap_bad && !vpp_gpio_en; // R13 R14
  assign wr_addr = lk_start ? paddr_q : xs_addr;
  assign wr_data = lk_start ? link.wdata : xs_data;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // The programming voltage sense arrives from outside the clock domain.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vpp_s1_q <= 1'b0;
      vpp_s2_q <= 1'b0;
    end else begin
      vpp_s1_q <= link.vpp_on;
      vpp_s2_q <= vpp_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Byte programming
  // ----------------------------------------------------------------
  // A byte that is already programmed is never rewritten.
  always_ff @(posedge sys_clk) begin
    if ((lk_start || iap_start) && !done_q[wr_addr]) begin // R12
      mem_q[wr_addr] <= wr_data; // R1
      done_q[wr_addr] <= 1'b1; // R1
    end
  end

  // Busy counts program time; the error flag holds the outcome.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      err_q <= 1'b0;
      gap_q <= 8'h00;
    end else if (dev_reset) begin
      cnt_q <= 8'h00;
      err_q <= 1'b0;
      gap_q <= 8'h00;
    end else begin
      if (lk_start || iap_start) begin
        cnt_q <= 8'(PROG_CYC); // R23
        err_q <= done_q[wr_addr]; // R8
      end else if (busy) begin
        cnt_q <= cnt_q - 8'h01; // R23
      end else if (link.req && link.we && link.sel == SEL_PDATA) begin
        err_q <= 1'b1; // R8 R20
      end else if (xs_valid && store_we_q) begin
        err_q <= 1'b1; // R13
      end
      // Gap timer saturates at the least wait.
      if (busy || lk_start || iap_start) begin
        gap_q <= 8'h00;
      end else if (gap_q < 8'(HWD_CYC)) begin
        gap_q <= gap_q + 8'h01; // R17
      end
    end
  end

  // ----------------------------------------------------------------
  // Link register access
  // ----------------------------------------------------------------
  // Each request gets a one-cycle ack one cycle later.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.ack <= 1'b0;
      link.rdata <= 8'h00;
      pm_q <= PM_OFF;
      rst_arm_q <= 1'b0;
      paddr_q <= 16'h0000;
      core_hold <= 1'b0;
    end else if (dev_reset) begin
      link.ack <= 1'b0;
      pm_q <= PM_OFF;
      rst_arm_q <= 1'b0;
      paddr_q <= 16'h0000;
      core_hold <= 1'b0;
    end else begin
      link.ack <= link.req;
      if (link.req && link.addr_rd) begin
        link.rdata <= {busy, err_q, 6'h00}; // R8
      end else if (link.req && !link.we) begin
        if (link.sel == SEL_PADDRH) begin
          link.rdata <= paddr_q[15:8];
        end else if (link.sel == SEL_PADDRL) begin
          link.rdata <= paddr_q[7:0];
        end else if (link.sel == SEL_PDATA) begin
          // Locked reads see zero, bar the security byte.
          if (!rlock || paddr_q == sec_addr) begin // R19 R21
            link.rdata <= rd_byte(paddr_q);
          end else begin
            link.rdata <= 8'h00; // R21
          end
          paddr_q <= paddr_q + 16'h0001;
        end else begin
          link.rdata <= 8'h00;
        end
      end else if (link.req && link.we) begin
        if (link.sel == SEL_DEVICE_CONTROL_REG) begin
          if (link.wdata == DEVICE_CONTROL_REG_HOLD) begin
            core_hold <= 1'b1; // R3
          end
          rst_arm_q <= (link.wdata == DEVICE_CONTROL_REG_RST); // R11
        end else if (link.sel == SEL_PCTL) begin
          // Two-step entry and exit; a wrong value drops the step.
          case (pm_q)
            PM_OFF: pm_q <= (link.wdata == PCTL_ARM) ? PM_ARM : PM_OFF;
            PM_ARM: begin
              if (link.wdata == PCTL_ON_NEW || link.wdata == PCTL_ON_OLD) begin
                pm_q <= PM_ON; // R4 R5
              end else begin
                pm_q <= PM_OFF;
              end
            end
            PM_ON: pm_q <= (link.wdata == PCTL_ARM) ? PM_EXIT : PM_ON;
            PM_EXIT: pm_q <= (link.wdata == PCTL_OFF) ? PM_OFF : PM_ON; // R10
            default: pm_q <= PM_OFF;
          endcase
        end else if (link.sel == SEL_PADDRH) begin
          paddr_q[15:8] <= link.wdata; // R6 R9
        end else if (link.sel == SEL_PADDRL) begin
          paddr_q[7:0] <= link.wdata; // R6 R9
        end else if (lk_start) begin
          paddr_q <= paddr_q + 16'h0001; // R7
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Device reset
  // ----------------------------------------------------------------
  // One-cycle pulse from the link sequence or an unprotected store.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_reset <= 1'b0;
    end else begin
      dev_reset <= (link.req && link.we && link.sel == SEL_DEVICE_CONTROL_REG &&
        rst_arm_q && link.wdata == DEVICE_CONTROL_REG_GO) || // R11
        (iap_try && iap_bad && !dev_reset); // R16
    end
  end

  // ----------------------------------------------------------------
  // Firmware control registers
  // ----------------------------------------------------------------
  // The key is consumed by every store, so each byte needs a fresh pair.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      store_we_q <= 1'b0;
      key_q <= 2'd0;
      iap_en_q <= 1'b0;
      hwd_pend_q <= 1'b0;
      vmon_q <= 1'b0;
      rsrc_q <= 1'b0;
      vpp_gpio_en <= 1'b0;
    end else if (dev_reset) begin
      store_we_q <= 1'b0;
      key_q <= 2'd0;
      iap_en_q <= 1'b0;
      hwd_pend_q <= 1'b0;
      vmon_q <= 1'b0;
      rsrc_q <= 1'b0;
      vpp_gpio_en <= 1'b0;
    end else begin
      if (xs_valid) begin
        key_q <= 2'd0; // R13
      end else if (sfr_we && sfr_addr == SFR_KEY) begin
        if (key_q == 2'd0 && sfr_wdata == KEY_1) begin
          key_q <= 2'd1; // R13
        end else if (key_q == 2'd1 && sfr_wdata == KEY_2) begin
          key_q <= 2'd2; // R13
        end else begin
          key_q <= 2'd0;
        end
      end
      if (sfr_we && sfr_addr == SFR_STORE) begin
        store_we_q <= sfr_wdata[0]; // R13
      end
      if (sfr_we && sfr_addr == SFR_IAP) begin
        iap_en_q <= sfr_wdata[IAP_EN_BIT]; // R14
        if (sfr_wdata[IAP_HWD_BIT]) begin
          hwd_pend_q <= 1'b1; // R17
        end
      end
      if (sfr_we && sfr_addr == SFR_VMON) begin
        vmon_q <= sfr_wdata[VMON_EN_BIT]; // R16
      end
      if (sfr_we && sfr_addr == SFR_RSRC) begin
        rsrc_q <= sfr_wdata[RSRC_VMON_BIT]; // R16
      end
      // Disable takes effect only once the least gap has passed.
      if (hwd_pend_q && !busy && gap_q >= 8'(HWD_CYC)) begin
        vpp_gpio_en <= 1'b1; // R17
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt holding
  // ----------------------------------------------------------------
  // Requests collect while busy; a new request wins over the clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 4'h0;
      irq_valid <= 1'b0;
      irq_id <= 2'd0;
    end else begin
      irq_valid <= 1'b0;
      pend_q <= pend_q | irq_req; // R22
      if (!busy && irq_enable && !irq_valid && pend_q != 4'h0) begin
        irq_valid <= 1'b1; // R22
        // Lowest index has the highest priority.
        for (int i = 3; i >= 0; i--) begin
          if (pend_q[i]) begin
            irq_id <= 2'(i);
          end
        end
        for (int i = 0; i < 4; i++) begin
          if (pend_q[i] && (pend_q & ((4'h1 << i) - 4'h1)) == 4'h0) begin
            pend_q[i] <= irq_req[i]; // R22
          end
        end
      end
    end
  end

endmodule : opw_device
`default_nettype wire

// ---- opw_programmer.sv ----
// Programmer end: bus-controlled driver of the debug programming link.
`timescale 1ns/1ps
`default_nettype none
module opw_programmer #(
  parameter int RST_WAIT = opw_pkg::RST_WAIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Device pin reset
  output logic dut_rst_n,
  // Programming link
  opw_link_if.prg link
);
  import opw_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic wr_ph_q; // Write data phase pending.
  logic [31:0] wa_q; // Address of that write.
  logic pend_q; // Command waiting to be issued.
  logic out_q; // Request outstanding on the link.
  logic [7:0] last_q; // Last data returned by the device.
  logic [31:0] wait_q; // Post-reset hold-off counter.
  logic aphase;

  assign aphase = hsel && htrans[1] && hready;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // Zero wait states: read data is captured in the address phase.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_ph_q <= 1'b0;
      wa_q <= 32'h0000_0000;
    end else begin
      wr_ph_q <= aphase && hwrite;
      wa_q <= haddr;
      if (aphase && !hwrite) begin
        if (haddr == HREG_STAT) begin
          hrdata <= {16'h0000, last_q, 5'h00, wait_q != 32'h0,
            pend_q, out_q};
        end else if (haddr == HREG_PIN) begin
          hrdata <= {30'h0, link.vpp_on, ~dut_rst_n};
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins and hold-off
  // ----------------------------------------------------------------
  // Commands wait out the hold-off after a pin reset.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dut_rst_n <= 1'b1;
      link.vpp_on <= 1'b0;
      wait_q <= 32'h0;
    end else begin
      if (wr_ph_q && wa_q == HREG_PIN) begin
        dut_rst_n <= ~hwdata[0];
        link.vpp_on <= hwdata[1];
      end
      if (!dut_rst_n) begin
        wait_q <= 32'(RST_WAIT); // R2
      end else if (wait_q != 32'h0) begin
        wait_q <= wait_q - 32'h1; // R2
      end
    end
  end

  // ----------------------------------------------------------------
  // Link command sequencer
  // ----------------------------------------------------------------
  // Latch a command, issue it after hold-off, keep its answer.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
      out_q <= 1'b0;
      last_q <= 8'h00;
      link.req <= 1'b0;
      link.addr_rd <= 1'b0;
      link.we <= 1'b0;
      link.sel <= 8'h00;
      link.wdata <= 8'h00;
    end else begin
      link.req <= 1'b0;
      if (wr_ph_q && wa_q == HREG_CMD && !pend_q && !out_q) begin
        pend_q <= 1'b1;
        link.sel <= hwdata[7:0];
        link.wdata <= hwdata[15:8];
        link.we <= hwdata[16];
        link.addr_rd <= hwdata[17];
      end else if (pend_q && wait_q == 32'h0 && dut_rst_n) begin
        pend_q <= 1'b0;
        out_q <= 1'b1;
        link.req <= 1'b1; // R3 R4 R10 R11
      end else if (out_q && link.ack) begin
        out_q <= 1'b0;
        last_q <= link.rdata; // R8
      end
    end
  end

endmodule : opw_programmer
`default_nettype wire

// ---- opw_asserts.sv ----
// Link protocol checker for the programmer and device pair.
`timescale 1ns/1ps
`default_nettype none
module opw_asserts
  import opw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link signals
  input wire logic req,
  input wire logic addr_rd,
  input wire logic we,
  input wire logic [7:0] sel,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic vpp_on
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  wire logic dwr = req && we && (sel == SEL_PDATA); // Data write request.
  logic [5:0] idle_q; // Cycles since the last data write, saturating.
  // Saturates: only "long ago" matters here.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= 6'h3f;
    end else if (dwr) begin
      idle_q <= 6'h00;
    end else if (idle_q != 6'h3f) begin
      idle_q <= idle_q + 6'h01;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_ack_follows; req |=> ack; endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("no ack");
  property p_no_stray; !req |=> !ack; endproperty
  a_no_stray: assert property (p_no_stray) else $error("stray ack");
  property p_ack_once; ack |=> !ack; endproperty
  a_ack_once: assert property (p_ack_once) else $error("long ack");
  property p_req_gap; req |=> !req [*2]; endproperty
  a_req_gap: assert property (p_req_gap) else $error("req gap");
  property p_rdata_hold; !ack |-> $stable(rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  property p_stat_fmt; (req && addr_rd) |=> ack && rdata[5:0] == 6'h00;
  endproperty
  a_stat_fmt: assert property (p_stat_fmt) else $error("bad status");
  property p_busy_set;
    dwr ##[2:15] (req && addr_rd) |=> rdata[ST_BUSY] || rdata[ST_ERR];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy low");
  property p_busy_clr;
    (req && addr_rd && idle_q >= 6'd30) |=> !rdata[ST_BUSY];
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy stuck");
  c_dwr: cover property (dwr);
  c_busy: cover property (ack && rdata[ST_BUSY]);
  c_err: cover property (ack && rdata[ST_ERR]);
endmodule : opw_asserts
`default_nettype wire

// ---- otp_program_memory_writer_bench.sv ----
// Bench for programmer and device on one link.
`timescale 1ns/1ps
`default_nettype none
module otp_program_memory_writer_bench;
  import opw_pkg::*;
  logic sys_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, sfr_we = 0;
  logic xs_valid = 0, irq_enable = 0, hready, hresp, dut_rst_n, irq_valid;
  logic core_hold, dev_reset, vpp_gpio_en;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, irq_id;
  logic [2:0] hsize = 3'h2;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, xs_data = 0;
  logic [15:0] xs_addr = 0;
  logic [3:0] irq_req = 0;
  wire logic dev_rst_n = rst_n & dut_rst_n; // Pin reset joins bench reset.
  int errors = 0, num_checks = 0, n_rst = 0, n_irq = 0;
  opw_link_if link();
  opw_programmer #(.RST_WAIT(16)) opw_programmer_inst(.sys_clk(sys_clk),
    .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .dut_rst_n(dut_rst_n), .link(link));
  opw_device opw_device_inst(.sys_clk(sys_clk), .rst_n(dev_rst_n),
    .link(link), .sfr_we(sfr_we), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .xs_valid(xs_valid), .xs_addr(xs_addr),
    .xs_data(xs_data), .irq_req(irq_req), .irq_enable(irq_enable),
    .irq_valid(irq_valid), .irq_id(irq_id), .core_hold(core_hold),
    .dev_reset(dev_reset), .vpp_gpio_en(vpp_gpio_en));
  opw_asserts opw_asserts_inst(.sys_clk(sys_clk), .rst_n(dev_rst_n),
    .req(link.req), .addr_rd(link.addr_rd), .we(link.we), .sel(link.sel),
    .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
    .vpp_on(link.vpp_on));
  always #25 sys_clk = ~sys_clk;
  // Count device reset and interrupt pulses.
  always @(posedge sys_clk) begin
    n_rst += (dev_reset === 1'b1);
    n_irq += (irq_valid === 1'b1);
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One word transfer; waits out both phases.
  task automatic ahb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  // Issue a link command, await it, check read data.
  task automatic op(input logic [7:0] s, d, input logic w, st,
                    input logic [7:0] e);
    logic [31:0] x;
    int n;
    ahb(1'b1, HREG_CMD, {14'h0, st, w, d, s}, x);
    n = 0;
    do begin
      ahb(1'b0, HREG_STAT, 32'h0, x);
      n++;
    end while (x[1:0] !== 2'b00 && n < 100);
    chk({6'h0, x[1:0]}, 8'h00);
    if (!w) chk(x[15:8], e);
  endtask : op
  task automatic wr(input logic [7:0] s, d);
    op(s, d, 1'b1, 1'b0, 8'h00);
  endtask : wr
  task automatic rd(input logic [7:0] e);
    op(SEL_PDATA, 8'h00, 1'b0, 1'b0, e);
  endtask : rd
  task automatic at(input logic [15:0] a);
    wr(SEL_PADDRH, a[15:8]);
    wr(SEL_PADDRL, a[7:0]);
  endtask : at
  task automatic dw(input logic [7:0] d, input logic [7:0] e);
    wr(SEL_PDATA, d);
    op(8'h00, 8'h00, 1'b0, 1'b1, e);
    repeat (25) @(posedge sys_clk);
  endtask : dw
  // Firmware register write (x=0) or external-data store (x=1).
  task automatic fw(input logic x, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_we <= !x;
    xs_valid <= x;
    sfr_addr <= a[7:0];
    sfr_wdata <= d;
    xs_addr <= a;
    xs_data <= d;
    @(posedge sys_clk);
    sfr_we <= 1'b0;
    xs_valid <= 1'b0;
  endtask : fw
  task automatic t_iap();
    int n;
    fw(0, SFR_STORE, 8'h01);
    fw(0, SFR_KEY, KEY_1);
    fw(0, SFR_KEY, KEY_2);
    fw(0, SFR_IAP, 8'h80);
    fw(1, 16'h2000, 8'h11);
    repeat (3) @(posedge sys_clk);
    chk(8'(n_rst), 8'h01);
    fw(0, SFR_VMON, 8'h80);
    fw(0, SFR_RSRC, 8'h02);
    fw(0, SFR_STORE, 8'h01);
    fw(0, SFR_IAP, 8'h80);
    fw(1, 16'h2001, 8'h22);
    fw(0, SFR_KEY, KEY_1);
    fw(0, SFR_KEY, KEY_2);
    fw(1, 16'h2002, 8'h33);
    irq_req <= 4'h4;
    irq_enable <= 1'b1;
    @(posedge sys_clk);
    irq_req <= 4'h0;
    fw(1, 16'h2003, 8'h44);
    chk(8'(n_irq), 8'h00);
    repeat (30) @(posedge sys_clk);
    chk(8'(n_irq), 8'h01);
    chk({6'h0, irq_id}, 8'h02);
    fw(0, SFR_IAP, 8'h00);
    fw(0, SFR_IAP, 8'h40);
    n = 0;
    while (vpp_gpio_en !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    chk({7'h0, vpp_gpio_en}, 8'h01);
  endtask : t_iap
  task automatic t_link();
    logic [31:0] x;
    ahb(1'b1, HREG_PIN, 32'h1, x);
    ahb(1'b1, HREG_PIN, 32'h0, x);
    wr(SEL_DEVICE_CONTROL_REG, DEVICE_CONTROL_REG_HOLD);
    chk({7'h0, core_hold}, 8'h01);
    wr(SEL_PCTL, PCTL_ARM);
    ahb(1'b1, HREG_PIN, 32'h2, x);
    dw(8'h01, 8'h40);
    wr(SEL_PCTL, PCTL_ON_NEW);
    at(16'h1234);
    dw(8'h5a, 8'h80);
    dw(8'h3c, 8'h80);
    at(16'h1234);
    dw(8'h00, 8'hc0);
    at(16'h1234);
    rd(8'h5a);
    rd(8'h3c);
    at(16'h2000);
    rd(8'hff);
    rd(8'hff);
    rd(8'h33);
    rd(8'hff);
    wr(SEL_PCTL, PCTL_ARM);
    wr(SEL_PCTL, PCTL_OFF);
    dw(8'h01, 8'h40);
    wr(SEL_PCTL, PCTL_ARM);
    wr(SEL_PCTL, PCTL_ON_OLD);
    at(SEC_ADDR_LARGE);
    dw(8'h05, 8'h80);
    dw(8'h01, 8'h40);
    at(16'h1234);
    rd(8'h00);
    at(SEC_ADDR_LARGE);
    rd(8'h05);
    wr(SEL_DEVICE_CONTROL_REG, DEVICE_CONTROL_REG_RST);
    wr(SEL_DEVICE_CONTROL_REG, DEVICE_CONTROL_REG_GO);
    chk(8'(n_rst), 8'h02);
  endtask : t_link
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_iap();
    t_link();
    complete_run();
  end
  initial begin
    #2_000_000;
    errors++;
    complete_run();
  end
endmodule : otp_program_memory_writer_bench
`default_nettype wire
